// File: verif/host_ctrl_model.sv
// host memory controller model driving the command pins of the core
`timescale 1ns/10ps
module host_ctrl_model
  import sdram_core_pkg::*;
(
  input  wire logic          clk_in,
  output logic               clk_en_out,
  output logic               sel_n_out,
  output logic [2:0]         strobe_n_out,
  output logic [ROW_W-1:0]   addr_out,
  output logic [BANK_W-1:0]  bank_out,
  output logic               mask_out,
  output logic [DATA_W-1:0]  wdata_out
);
  // 200 us of idle commands at 20 MHz
  localparam int PWR_CYC = 4000;

  initial begin
    clk_en_out   = 1'b1;
    sel_n_out    = 1'b0;
    strobe_n_out = 3'h7;
    addr_out     = '0;
    bank_out     = '0;
    mask_out     = 1'b1;
    wdata_out    = 16'h0000;
  end

  // data moves with every cmd call so a stale beat never looks valid
  task automatic cmd(input logic [2:0] s, input logic [1:0] b, input logic [11:0] a, input logic m);
    @(posedge clk_in);
    sel_n_out    <= 1'b0;
    strobe_n_out <= s;
    bank_out     <= b;
    addr_out     <= a;
    mask_out     <= m;
    wdata_out    <= wdata_out + 16'h1357;
  endtask

  task automatic desel(input logic [2:0] s);
    @(posedge clk_in);
    sel_n_out    <= 1'b1;
    strobe_n_out <= s;
  endtask

  task automatic cke(input logic v);
    @(posedge clk_in);
    clk_en_out   <= v;
    sel_n_out    <= 1'b0;
    strobe_n_out <= 3'h7;
  endtask

  // callers load only with all banks idle and valid, zeroed fields
  task automatic mode(input logic [11:0] a);
    cmd(3'h0, 2'h0, a, 1'b0);
    cmd(3'h7, 2'h0, 12'h000, 1'b0);
  endtask

  task automatic powerup();
    repeat (PWR_CYC) cmd(3'h7, 2'h0, 12'h000, 1'b1);
    cmd(3'h2, 2'h0, 12'h400, 1'b1);
    repeat (2) begin
      cmd(3'h1, 2'h0, 12'h000, 1'b1);
      repeat (4) cmd(3'h7, 2'h0, 12'h000, 1'b1);
    end
  endtask
endmodule

// File: verif/sdram_mode_and_command_core_test.sv
// self-checking bench for the sdram mode and command core
`timescale 1ns/10ps
module sdram_mode_and_command_core_test;
  import sdram_core_pkg::*;
  localparam logic [2:0] S_MODE = 3'h0, S_PRE = 3'h2, S_ACT = 3'h3, S_WR = 3'h4;
  localparam logic [2:0] S_RD = 3'h5, S_STOP = 3'h6, S_NOP = 3'h7;
  logic                clk_in = 1'b0;
  logic                sys_rst_in = 1'b1;
  logic                clk_en, sel_n, mask, rdata_oe_n_out, wr_strobe_out;
  logic                mode_busy_out, power_down_out, suspend_out, saw_susp = 1'b0;
  logic [2:0]          strobe_n;
  logic [ROW_W-1:0]    addr, row_latch_out;
  logic [BANK_W-1:0]   bank, wr_bank_out;
  logic [DATA_W-1:0]   wdata, rdata_out, wr_data_out;
  logic [COL_W-1:0]    mem_col_out;
  logic [3:0]          bank_open_out;
  logic [MODE_W-1:0]   mode_out;
  logic [COL_W-1:0]    cols[$];
  int                  num_errors = 0;
  int                  n_checks = 0;

  always #25 clk_in = ~clk_in;

  host_ctrl_model host_u (.clk_in(clk_in), .clk_en_out(clk_en), .sel_n_out(sel_n), .strobe_n_out(strobe_n),
    .addr_out(addr), .bank_out(bank), .mask_out(mask), .wdata_out(wdata));

  sdram_mode_cmd_core dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en), .sel_n_in(sel_n),
    .row_strobe_n_in(strobe_n[2]), .col_strobe_n_in(strobe_n[1]), .wr_en_n_in(strobe_n[0]), .addr_in(addr),
    .bank_sel_lo_in(bank[0]), .bank_sel_hi_in(bank[1]), .byte_mask_in(mask), .wdata_in(wdata),
    .rdata_out(rdata_out), .rdata_oe_n_out(rdata_oe_n_out), .wr_strobe_out(wr_strobe_out),
    .wr_data_out(wr_data_out), .wr_bank_out(wr_bank_out), .mem_col_out(mem_col_out),
    .bank_open_out(bank_open_out), .row_latch_out(row_latch_out), .mode_out(mode_out),
    .mode_busy_out(mode_busy_out), .power_down_out(power_down_out), .suspend_out(suspend_out));

  always @(posedge clk_in) begin
    if (wr_strobe_out === 1'b1) cols.push_back(mem_col_out);
    if (suspend_out === 1'b1) saw_susp <= 1'b1;
  end

  ////////////////////////////////////////////////////////////
  task automatic summarize();
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (e !== g) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // idle command, then look once its edge has landed
  task automatic settle();
    host_u.cmd(S_NOP, 2'h0, 12'h000, 1'b0);
    #1;
  endtask

  function automatic logic [7:0] ecol(input logic [7:0] s, input int i, input int len, input logic il);
    logic [7:0] m;
    m = 8'(len - 1);
    ecol = il ? ((s & ~m) | ((s ^ 8'(i)) & m)) : ((s & ~m) | ((s + 8'(i)) & m));
  endfunction

  // write burst to bank 1: optional clock-enable gap and one masked beat
  task automatic burst(input logic [11:0] md, input logic [7:0] c, input int beats, input int susp,
                       input int mbeat, input logic [2:0] tail);
    host_u.mode(md);
    host_u.cmd(S_ACT, 2'h1, 12'h000, 1'b0);
    cols.delete();
    host_u.cmd(S_WR, 2'h1, {4'h0, c}, mbeat == 0);
    for (int i = 1; i < beats; i++) begin
      if (i == susp) begin
        host_u.cke(1'b0);
        host_u.cke(1'b0);
        host_u.cke(1'b1);
      end
      host_u.cmd(S_NOP, 2'h1, 12'h000, mbeat == i);
    end
    host_u.cmd(tail, 2'h1, 12'h000, 1'b0);
    host_u.cmd(S_PRE, 2'h1, 12'h400, 1'b0);
    repeat (3) settle();
  endtask

  task automatic rd(input logic [2:0] lc, input logic m, input int e);
    int n;
    n = 0;
    host_u.mode({5'h00, lc, 1'b0, BL_1});
    host_u.cmd(S_ACT, 2'h2, 12'hA5C, 1'b0);
    host_u.cmd(S_RD, 2'h2, 12'h03C, m);
    do begin
      settle();
      n++;
    end while (rdata_oe_n_out !== 1'b0 && n < 8);
    chk("rd_lat", e, n);
    if (m == 1'b0) chk("rd_data", {16'h0000, 16'h5C3C}, rdata_out);
    host_u.cmd(S_PRE, 2'h2, 12'h400, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    summarize();
  end

  initial begin
    logic [2:0] code;
    int         len;
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    settle();
    chk("mode_rst", MODE_RST, mode_out);
    chk("oe_rst", 1'b1, rdata_oe_n_out);
    host_u.powerup();
    host_u.cmd(S_MODE, 2'h0, 12'h023, 1'b0);
    host_u.cmd(S_ACT, 2'h0, 12'h001, 1'b0);
    #1;
    chk("busy", 1'b1, mode_busy_out);
    settle();
    chk("mode", 14'h0023, mode_out);
    chk("refused", 4'h0, bank_open_out);
    for (int b = 0; b < 4; b++) begin
      host_u.cmd(S_ACT, 2'(b), 12'(12'h111 * b + 12'h00F), 1'b0);
      settle();
      chk("open", 1'b1, bank_open_out[b]);
      chk("row", 12'(12'h111 * b + 12'h00F), row_latch_out);
    end
    host_u.cmd(S_PRE, 2'h2, 12'h000, 1'b0);
    settle();
    chk("pre_one", 4'hB, bank_open_out);
    host_u.cmd(S_PRE, 2'h1, 12'h400, 1'b0);
    settle();
    chk("pre_all", 4'h0, bank_open_out);
    host_u.desel(S_ACT);
    settle();
    chk("desel", 4'h0, bank_open_out);
    host_u.cke(1'b0);
    settle();
    settle();
    chk("pdown", 1'b1, power_down_out);
    host_u.cmd(S_ACT, 2'h0, 12'h000, 1'b0);
    settle();
    chk("pd_ignore", 4'h0, bank_open_out);
    host_u.cke(1'b1);
    settle();
    settle();
    host_u.cmd(S_ACT, 2'h3, 12'h000, 1'b0);
    settle();
    chk("pd_exit", 4'h8, bank_open_out);
    host_u.cmd(S_PRE, 2'h0, 12'h400, 1'b0);
    for (int k = 0; k < 10; k++) begin
      code = (k / 2 == 4) ? BL_PAGE : 3'(k / 2);
      len  = (code == BL_PAGE) ? 256 : (1 << code);
      burst({5'h00, RL_2, k[0], code}, 8'hFD, len, -1, -1, S_NOP);
      chk("beats", len, cols.size());
      chk("wr_bank", 2'h1, wr_bank_out);
      foreach (cols[i]) chk("col", ecol(8'hFD, i, len, k[0] && len <= 8), cols[i]);
    end
    burst({5'h00, RL_2, 1'b0, BL_4}, 8'h06, 6, 1, -1, S_NOP);
    chk("susp", 1'b1, saw_susp);
    chk("susp_beats", 4, cols.size());
    foreach (cols[i]) chk("susp_col", ecol(8'h06, i, 4, 1'b0), cols[i]);
    burst({5'h00, RL_2, 1'b0, BL_4}, 8'h06, 4, -1, 2, S_NOP);
    chk("mask_beats", 3, cols.size());
    chk("mask_col", 8'h05, cols[2]);
    burst({5'h00, RL_2, 1'b0, BL_8}, 8'h00, 2, -1, -1, S_STOP);
    chk("stop_beats", 2, cols.size());
    burst({2'h0, 1'b1, 2'h0, RL_2, 1'b0, BL_4}, 8'h06, 4, -1, -1, S_NOP);
    chk("single", 1, cols.size());
    rd(RL_2, 1'b0, 3);
    rd(RL_3, 1'b0, 4);
    rd(RL_2, 1'b1, 8);
    summarize();
  end
endmodule

// File: verilog/burst_addr_gen.sv
// burst column sequence generator
`timescale 1ns/10ps
module burst_addr_gen
  import sdram_core_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   sys_rst_in,
  burst_addr_if.gen   bus
);
  logic [COL_W-1:0] base_r;
  logic [COL_W-1:0] beat_r;
  logic [COL_W-1:0] mask;
  logic [8:0]       len;

  always_comb begin
    case (bus.len_code)
      BL_1:    len = 9'h001;
      BL_2:    len = 9'h002;
      BL_4:    len = 9'h004;
      BL_8:    len = 9'h008;
      default: len = PAGE_LEN;
    endcase
    mask = COL_W'(len - 9'h001);
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      base_r <= '0;
      beat_r <= '0;
    end else if (bus.start) begin
      base_r <= bus.start_col;
      // a write takes beat zero with the command, so it starts one beat on
      beat_r <= bus.step ? 8'h01 : 8'h00;
    end else if (bus.step) begin
      beat_r <= beat_r + 8'h01;
    end
  end

  // sequential wraps inside burst, interleave xors beat
  always_comb begin
    if (bus.order && bus.len_code != BL_PAGE)
      bus.col = (base_r & ~mask) | ((base_r ^ beat_r) & mask);
    else
      bus.col = (base_r & ~mask) | ((base_r + beat_r) & mask);
  end
  assign bus.last = ((beat_r & mask) == mask);
endmodule

// File: verilog/burst_addr_if.sv
// burst address carrier between core and address generator
`timescale 1ns/10ps
interface burst_addr_if;
  import sdram_core_pkg::*;
  logic             start;
  logic             step;
  logic [COL_W-1:0] start_col;
  logic [2:0]       len_code;
  logic             order;
  logic [COL_W-1:0] col;
  logic             last;
  modport core (output start, step, start_col, len_code, order, input col, last);
  modport gen  (input start, step, start_col, len_code, order, output col, last);
endinterface

// File: verilog/sdram_core_pkg.sv
// constants and types for the sdram mode and command core
package sdram_core_pkg;
  localparam int ROW_W       = 12;
  localparam int COL_W       = 8;
  localparam int BANK_W      = 2;
  localparam int NUM_BANKS   = 4;
  localparam int DATA_W      = 16;
  localparam int MODE_W      = 14;
  // mode field positions, then the auto-precharge address bit
  localparam int BL_LSB      = 0;
  localparam int BT_BIT      = 3;
  localparam int RL_LSB      = 4;
  localparam int TEST_LSB    = 7;
  localparam int WB_BIT      = 9;
  localparam int AP_BIT      = 10;
  // field encodings
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] RL_2    = 3'h2;
  localparam logic [2:0] RL_3    = 3'h3;
  localparam logic [1:0] TEST_NORMAL = 2'h0;
  localparam logic [8:0] PAGE_LEN    = 9'h100;
  // timing in cycles, then mode reset value
  localparam logic [1:0] MODE_BUSY_CYC = 2'h2;
  localparam int         READ_MASK_LAT = 2;
  localparam logic [MODE_W-1:0] MODE_RST = 14'h0000;

  typedef enum logic [2:0] {
    CMD_IDLE     = 3'h0,
    CMD_MODE     = 3'h1,
    CMD_REFRESH  = 3'h2,
    CMD_ACTIVATE = 3'h3,
    CMD_READ     = 3'h4,
    CMD_WRITE    = 3'h5,
    CMD_PRECH    = 3'h6,
    CMD_STOP     = 3'h7
  } cmd_t;

  // gray coded along idle -> burst -> idle
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BURST = 2'b01,
    ST_SUSP  = 2'b11,
    ST_PDOWN = 2'b10
  } state_t;
endpackage

// File: verilog/sdram_mode_cmd_core.sv
// command decoder, mode register and burst control of the sdram device
`timescale 1ns/10ps
// Functional notes
// - two cycles after mode load before any new command
// - bank select bits decode to banks A through D
// - precharge-all flag precharges every bank, ignoring bank bits
// - burst stop ends the current burst at every length
// - byte mask blocks writes at once, reads two cycles later
// - mode fields taken from address bits at mode load
// - read latency codes 2 and 3 valid, others reserved
// - burst length codes 1,2,4,8 and full page of 256
// - full page only with sequential order
// - sequential wraps, interleaved is start column xor beat
// - address bit 9 high makes writes single word
// - mode undefined at power-up, loaded by all-low command; the code loads MODE_RST (14'h0000) at reset
// - low clock enable freezes state and ignores inputs
// - low clock enable with banks idle enters power-down
// - idle command continues operations, deselect ignores inputs
// - row bits on activate, column bits on read or write
module sdram_mode_cmd_core
  import sdram_core_pkg::*;
#(
  parameter int NBANK = NUM_BANKS
)(
  input  wire logic                 clk_in,
  input  wire logic                 sys_rst_in,
  input  wire logic                 clk_en_in,
  input  wire logic                 sel_n_in,
  input  wire logic                 row_strobe_n_in,
  input  wire logic                 col_strobe_n_in,
  input  wire logic                 wr_en_n_in,
  input  wire logic [ROW_W-1:0]     addr_in,
  input  wire logic                 bank_sel_lo_in,
  input  wire logic                 bank_sel_hi_in,
  input  wire logic                 byte_mask_in,
  input  wire logic [DATA_W-1:0]    wdata_in,
  output logic [DATA_W-1:0]         rdata_out,
  output logic                      rdata_oe_n_out,
  output logic                      wr_strobe_out,
  output logic [DATA_W-1:0]         wr_data_out,
  output logic [BANK_W-1:0]         wr_bank_out,
  output logic [COL_W-1:0]          mem_col_out,
  output logic [NBANK-1:0]          bank_open_out,
  output logic [ROW_W-1:0]          row_latch_out,
  output logic [MODE_W-1:0]         mode_out,
  output logic                      mode_busy_out,
  output logic                      power_down_out,
  output logic                      suspend_out
);
  cmd_t                cmd;
  state_t              state_r;
  logic                clk_en_r;
  logic                active;
  logic [BANK_W-1:0]   bank;
  logic [MODE_W-1:0]   mode_r;
  logic [1:0]          mode_cnt_r;
  logic [NBANK-1:0]    open_r;
  logic [NBANK-1:0]    prech_pend_r;
  logic [ROW_W-1:0]    row_r;
  logic [BANK_W-1:0]   burst_bank_r;
  logic                burst_wr_r;
  logic                burst_ap_r;
  logic [2:0]          lat_cnt_r;
  logic [READ_MASK_LAT-1:0] mask_pipe_r;
  logic                all_idle;
  logic [2:0]          rd_lat;
  logic [2:0]          eff_len;
  logic                burst_end;
  logic                in_burst;

  burst_addr_if ba ();
  burst_addr_gen u_gen (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .bus        (ba.gen)
  );

  ////////////////////////////////////////////////////////////////
  // command decode
  // internal clock runs only when clock enable was high last edge
  assign active = clk_en_r;
  assign bank   = {bank_sel_hi_in, bank_sel_lo_in};
  assign all_idle = (open_r == '0) && !in_burst;

  always_comb begin
    cmd = CMD_IDLE;
    if (!sel_n_in) begin
      case ({row_strobe_n_in, col_strobe_n_in, wr_en_n_in})
        3'b000:  cmd = CMD_MODE;
        3'b001:  cmd = clk_en_in ? CMD_REFRESH : CMD_IDLE;
        3'b011:  cmd = CMD_ACTIVATE;
        3'b101:  cmd = CMD_READ;
        3'b100:  cmd = CMD_WRITE;
        3'b010:  cmd = CMD_PRECH;
        3'b110:  cmd = CMD_STOP;
        default: cmd = CMD_IDLE;
      endcase
    end
    if (!active || mode_cnt_r != 2'h0)
      cmd = CMD_IDLE;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in)
      clk_en_r <= 1'b1;
    else
      clk_en_r <= clk_en_in;
  end

  ////////////////////////////////////////////////////////////////
  // mode register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mode_r     <= MODE_RST;
      mode_cnt_r <= 2'h0;
    end else begin
      if (cmd == CMD_MODE && all_idle) begin
        mode_r     <= {bank, addr_in};
        mode_cnt_r <= MODE_BUSY_CYC - 2'h1;
      end else if (mode_cnt_r != 2'h0)
        mode_cnt_r <= mode_cnt_r - 2'h1;
    end
  end

  always_comb begin
    case (mode_r[RL_LSB +: 3])
      RL_3:    rd_lat = 3'h3;
      default: rd_lat = 3'h2;
    endcase
    eff_len = mode_r[BL_LSB +: 3];
    if (burst_wr_r && mode_r[WB_BIT])
      eff_len = BL_1;
  end

  ////////////////////////////////////////////////////////////////
  // bank state and row latch
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      open_r       <= '0;
      prech_pend_r <= '0;
      row_r        <= '0;
    end else if (active) begin
      if (cmd == CMD_ACTIVATE) begin
        open_r[bank] <= 1'b1;
        row_r        <= addr_in;
      end else if (cmd == CMD_PRECH) begin
        if (addr_in[AP_BIT])
          open_r <= '0;
        else
          open_r[bank] <= 1'b0;
      end
      if ((cmd == CMD_READ || cmd == CMD_WRITE) && addr_in[AP_BIT])
        prech_pend_r[bank] <= 1'b1;
      if (burst_end && burst_ap_r) begin
        open_r[burst_bank_r]       <= 1'b0;
        prech_pend_r[burst_bank_r] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // burst control and state machine
  assign in_burst  = (state_r == ST_BURST) || (state_r == ST_SUSP);
  assign burst_end = (state_r == ST_BURST) &&
                     ((lat_cnt_r == 3'h0 && ba.last) || cmd == CMD_STOP);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_r      <= ST_IDLE;
      burst_bank_r <= '0;
      burst_wr_r   <= 1'b0;
      burst_ap_r   <= 1'b0;
      lat_cnt_r    <= 3'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (!clk_en_in && active)
            state_r <= ST_PDOWN;
          else if (cmd == CMD_READ || cmd == CMD_WRITE) begin
            state_r      <= ST_BURST;
            burst_bank_r <= bank;
            burst_wr_r   <= (cmd == CMD_WRITE);
            burst_ap_r   <= addr_in[AP_BIT];
            lat_cnt_r    <= (cmd == CMD_WRITE) ? 3'h0 : rd_lat - 3'h1;
          end
        end
        ST_BURST: begin
          if (!clk_en_in)
            state_r <= ST_SUSP;
          else if (cmd == CMD_READ || cmd == CMD_WRITE) begin
            burst_bank_r <= bank;
            burst_wr_r   <= (cmd == CMD_WRITE);
            burst_ap_r   <= addr_in[AP_BIT];
            lat_cnt_r    <= (cmd == CMD_WRITE) ? 3'h0 : rd_lat - 3'h1;
          end else if (burst_end)
            state_r <= ST_IDLE;
          else if (lat_cnt_r != 3'h0)
            lat_cnt_r <= lat_cnt_r - 3'h1;
        end
        ST_SUSP: begin
          if (clk_en_in)
            state_r <= ST_BURST;
        end
        default: begin
          if (clk_en_in)
            state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // address generator steering
  assign ba.start     = (cmd == CMD_READ || cmd == CMD_WRITE);
  assign ba.start_col = addr_in[COL_W-1:0];
  assign ba.len_code  = eff_len;
  assign ba.order     = mode_r[BT_BIT];
  // write command steps at once: its first beat is taken with the command
  assign ba.step      = (cmd == CMD_WRITE) ||
                        ((state_r == ST_BURST) && clk_en_in && lat_cnt_r == 3'h0 && !burst_end && cmd != CMD_READ);

  ////////////////////////////////////////////////////////////////
  // data path and byte mask
  always_ff @(posedge clk_in) begin
    if (sys_rst_in)
      mask_pipe_r <= '0;
    else if (active)
      mask_pipe_r <= {mask_pipe_r[READ_MASK_LAT-2:0], byte_mask_in};
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_strobe_out <= 1'b0;
      wr_data_out   <= '0;
      wr_bank_out   <= '0;
      mem_col_out   <= '0;
    end else begin
      wr_strobe_out <= 1'b0;
      if (active && cmd == CMD_WRITE && !byte_mask_in) begin
        wr_strobe_out <= 1'b1;
        wr_data_out   <= wdata_in;
        wr_bank_out   <= bank;
        mem_col_out   <= addr_in[COL_W-1:0];
      end else if (active && clk_en_in && state_r == ST_BURST && burst_wr_r && lat_cnt_r == 3'h0 &&
                   eff_len != BL_1 && cmd != CMD_STOP && cmd != CMD_READ && !byte_mask_in) begin
        wr_strobe_out <= 1'b1;
        wr_data_out   <= wdata_in;
        wr_bank_out   <= burst_bank_r;
        mem_col_out   <= ba.col;
      end else if (state_r == ST_BURST && clk_en_in)
        mem_col_out <= ba.col;
    end
  end

  // read data echoes the low row bits and the column; masked lane goes off two cycles after mask
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_out      <= '0;
      rdata_oe_n_out <= 1'b1;
    end else if (active) begin
      rdata_oe_n_out <= 1'b1;
      if (state_r == ST_BURST && clk_en_in && !burst_wr_r && lat_cnt_r == 3'h0 &&
          !mask_pipe_r[READ_MASK_LAT-1]) begin
        rdata_out      <= {row_r[DATA_W-COL_W-1:0], ba.col};
        rdata_oe_n_out <= 1'b0;
      end
    end
  end

  assign bank_open_out  = open_r;
  assign row_latch_out  = row_r;
  assign mode_out       = mode_r;
  assign mode_busy_out  = (mode_cnt_r != 2'h0);
  assign power_down_out = (state_r == ST_PDOWN);
  assign suspend_out    = (state_r == ST_SUSP);

  ////////////////////////////////////////////////////////////////
  // checks
  sequence s_mode_load;
    cmd == CMD_MODE && all_idle;
  endsequence

  AST_MODE_BUSY: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_mode_load |=> mode_busy_out ##1 !mode_busy_out)
    else $error("mode busy window wrong");
  AST_MODE_STORE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_mode_load |=> mode_r == $past({bank, addr_in}))
    else $error("mode register not loaded");
  AST_PRECH_ALL: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (active && cmd == CMD_PRECH && addr_in[AP_BIT] && !(burst_end && burst_ap_r)) |=> open_r == '0)
    else $error("precharge all left a bank open");
  AST_ACT_BANK: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (active && cmd == CMD_ACTIVATE) |=> open_r[$past(bank)])
    else $error("wrong bank opened");
  AST_DESELECT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    sel_n_in |-> cmd == CMD_IDLE)
    else $error("deselect decoded a command");
  AST_PDOWN: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state_r == ST_IDLE && active && !clk_en_in) |=> power_down_out)
    else $error("power down not entered");
  AST_WR_MASK: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (byte_mask_in && active) |=> !wr_strobe_out)
    else $error("masked write reached array");
  AST_RD_MASK: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (byte_mask_in && active) ##1 active ##1 active |=> rdata_oe_n_out)
    else $error("masked read drove data");
  AST_STOP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state_r == ST_BURST && cmd == CMD_STOP) |=> state_r == ST_IDLE)
    else $error("burst stop ignored");
  AST_SUSPEND: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    suspend_out |-> $stable(mem_col_out) && $stable(rdata_out))
    else $error("state moved while suspended");
endmodule
